// File: sensor_cmd_pkg.sv
package sensor_cmd_pkg;
    // Bus addresses and general call reset
    localparam logic [6:0]  DEV_ADDR      = 7'h70;
    localparam logic [7:0]  GC_WRITE      = 8'h00;
    localparam logic [7:0]  GC_RESET_BYTE = 8'h06;
    // Command words, high byte first on the wire
    localparam logic [15:0] CMD_SLEEP     = 16'hB098;
    localparam logic [15:0] CMD_WAKE      = 16'h3517;
    localparam logic [15:0] CMD_SOFT_RST  = 16'h805D;
    localparam logic [15:0] CMD_IDENTIFIER_READOUT_COMMAND   = 16'hEFC8;
    localparam logic [15:0] CMD_N_ST_T    = 16'h7CA2;
    localparam logic [15:0] CMD_N_ST_H    = 16'h5C24;
    localparam logic [15:0] CMD_N_NS_T    = 16'h7866;
    localparam logic [15:0] CMD_N_NS_H    = 16'h58E0;
    localparam logic [15:0] CMD_L_ST_T    = 16'h6458;
    localparam logic [15:0] CMD_L_ST_H    = 16'h44DE;
    localparam logic [15:0] CMD_L_NS_T    = 16'h609C;
    localparam logic [15:0] CMD_L_NS_H    = 16'h401A;
    // Product identifier; value is arbitrary
    localparam logic [15:0] PRODUCT_ID    = 16'h0A5C;
    // Checksum settings and a known vector
    localparam logic [7:0]  CRC_POLY      = 8'h31;
    localparam logic [7:0]  CRC_INIT      = 8'hFF;
    localparam logic [7:0]  CRC_CHK_HI    = 8'hBE;
    localparam logic [7:0]  CRC_CHK_LO    = 8'hEF;
    localparam logic [7:0]  CRC_CHK_VAL   = 8'h92;
    // Bit and byte counts
    localparam logic [3:0]  BYTE_BITS     = 4'h8;
    localparam logic [3:0]  BIT_LAST      = 4'h7;
    localparam logic [2:0]  IDX_HI1       = 3'h0;
    localparam logic [2:0]  IDX_LO1       = 3'h1;
    localparam logic [2:0]  IDX_CRC1      = 3'h2;
    localparam logic [2:0]  IDX_HI2       = 3'h3;
    localparam logic [2:0]  IDX_LO2       = 3'h4;
    localparam logic [2:0]  IDX_CRC2      = 3'h5;
    localparam logic [7:0]  IDLE_BYTE     = 8'hFF;

    // Link sequencer states
    typedef enum logic [8:0] {
        S_IDLE    = 9'h001,
        S_ADDR    = 9'h002,
        S_ACK     = 9'h004,
        S_WR      = 9'h008,
        S_WACK    = 9'h010,
        S_STRETCH = 9'h020,
        S_RD      = 9'h040,
        S_RACK    = 9'h080,
        S_WAIT    = 9'h100
    } link_state_t;

    // What a read header returns
    typedef enum logic [2:0] {
        RD_NONE = 3'h1,
        RD_MEAS = 3'h2,
        RD_ID   = 3'h4
    } read_kind_t;

    // Whole block state
    typedef struct packed {
        logic [2:0]  scl_s;
        logic [2:0]  sda_s;
        logic        scl_f;
        logic        sda_f;
        link_state_t st;
        logic [3:0]  bit_cnt;
        logic [7:0]  shreg;
        logic        rw;
        logic        is_gc;
        logic [2:0]  byte_idx;
        logic [7:0]  cmd_hi;
        logic        asleep;
        logic        busy;
        logic        stretch_sel;
        logic        low_power;
        logic        temp_first;
        read_kind_t  rd_kind;
        logic [7:0]  crc;
        logic        sda_oe_n;
        logic        scl_oe_n;
        logic        meas_start;
        logic        soft_rst;
    } dev_state_t;

    localparam dev_state_t ST_RST = '{
        scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1, st: S_IDLE,
        bit_cnt: 4'h0, shreg: 8'h00, rw: 1'b0, is_gc: 1'b0, byte_idx: 3'h0,
        cmd_hi: 8'h00, asleep: 1'b0, busy: 1'b0, stretch_sel: 1'b0,
        low_power: 1'b0, temp_first: 1'b0, rd_kind: RD_NONE, crc: 8'hFF,
        sda_oe_n: 1'b1, scl_oe_n: 1'b1, meas_start: 1'b0, soft_rst: 1'b0};
endpackage : sensor_cmd_pkg

// File: sensor_i2c_command_interface.sv
`timescale 1ns/1ps
// Function
// RQ1: Answer only target address 0x70.
// RQ2: Commands are 16 bits, high byte first.
// RQ3: Power-on puts command logic in idle.
// RQ4: Host should send sleep after power-up.
// RQ5: Asleep, only wake-up command is accepted; the general call reset (0x00, 0x06) still resets here.
// RQ6: Decode four normal-power measurement codes.
// RQ7: Decode four low-power measurement codes.
// RQ8: Host sequence: wake, measure, read, sleep.
// RQ9: No stretch conversion: NACK every header.
// RQ10: Stretch conversion: ACK read, hold SCL.
// RQ11: Host keeps bus quiet during conversion.
// RQ12: Send result, CRC, result, CRC.
// RQ13: No acknowledge: stop sending, release SDA.
// RQ14: Host may end readout with NACK.
// RQ15: Soft reset command acts as power-on.
// RQ16: General call 0x00 then 0x06 resets.
// RQ17: Identifier command returns ID and CRC.
// RQ18: CRC-8 poly 0x31, init 0xFF.
// RQ19: Host retries read header until acknowledged.
module sensor_i2c_command_interface (
    input  wire logic        clk_sys_in,
    input  wire logic        rst_in,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic        conv_done_in,
    input  wire logic [15:0] temp_in,
    input  wire logic [15:0] hum_in,
    output logic             scl_out,
    output logic             scl_oe_n_out,
    output logic             sda_out,
    output logic             sda_oe_n_out,
    output logic             meas_start_out,
    output logic             meas_low_power_out,
    output logic             meas_temp_first_out,
    output logic             sleep_out,
    output logic             soft_reset_out
);
    sensor_cmd_pkg::dev_state_t q_r;     // Registered state
    sensor_cmd_pkg::dev_state_t q_nxt;   // Next state
    logic                       scl_fv;  // Filtered clock, new value
    logic                       sda_fv;  // Filtered data, new value
    logic                       rise;    // Link clock rising edge
    logic                       fall;    // Link clock falling edge
    logic                       start;   // Start condition seen
    logic                       stop;    // Stop condition seen
    logic                       load;    // Load next transmit byte
    logic                       do_reset;
    logic                       addr_hit;
    logic [15:0]                cmd;
    logic [15:0]                first_w;
    logic [15:0]                second_w;
    logic [7:0]                 txb;
    logic                       tx_crc;  // Byte is a checksum
    logic                       tx_new;  // Byte opens a checksum group
    logic                       mv;
    logic                       ms;
    logic                       ml;
    logic                       mt;

    // Checksum of one byte, msb first, no reflection
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < int'(sensor_cmd_pkg::BYTE_BITS); i++) begin
            r = r[7] ? ((r << 1) ^ sensor_cmd_pkg::CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc8

    // Next state of the whole block
    always_comb begin
        q_nxt = q_r;
        // A change counts once second and third stage agree
        scl_fv = (q_r.scl_s[1] == q_r.scl_s[2]) ? q_r.scl_s[2] : q_r.scl_f;
        sda_fv = (q_r.sda_s[1] == q_r.sda_s[2]) ? q_r.sda_s[2] : q_r.sda_f;
        rise = scl_fv & ~q_r.scl_f;
        fall = ~scl_fv & q_r.scl_f;
        start = q_r.scl_f & scl_fv & q_r.sda_f & ~sda_fv;
        stop = q_r.scl_f & scl_fv & ~q_r.sda_f & sda_fv;
        q_nxt.scl_s = {q_r.scl_s[1:0], scl_in};
        q_nxt.sda_s = {q_r.sda_s[1:0], sda_in};
        q_nxt.scl_f = scl_fv;
        q_nxt.sda_f = sda_fv;
        q_nxt.meas_start = 1'b0;
        q_nxt.soft_rst = 1'b0;
        load = 1'b0;
        do_reset = 1'b0;
        {mv, ms, ml, mt} = 4'h0;
        cmd = {q_r.cmd_hi, q_r.shreg};
        // RQ1: address match
        addr_hit = (q_r.shreg[7:1] == sensor_cmd_pkg::DEV_ADDR) || (q_r.shreg == sensor_cmd_pkg::GC_WRITE);
        // Conversion end frees the link
        if (conv_done_in) begin
            q_nxt.busy = 1'b0;
        end

        // Transmit byte chooser
        first_w = q_r.temp_first ? temp_in : hum_in;
        second_w = q_r.temp_first ? hum_in : temp_in;
        txb = sensor_cmd_pkg::IDLE_BYTE;
        tx_crc = 1'b0;
        tx_new = (q_r.byte_idx == sensor_cmd_pkg::IDX_HI1) || (q_r.byte_idx == sensor_cmd_pkg::IDX_HI2);
        // RQ12: result order
        if (q_r.rd_kind == sensor_cmd_pkg::RD_MEAS) begin
            case (q_r.byte_idx)
                sensor_cmd_pkg::IDX_HI1:  txb = first_w[15:8];
                sensor_cmd_pkg::IDX_LO1:  txb = first_w[7:0];
                sensor_cmd_pkg::IDX_HI2:  txb = second_w[15:8];
                sensor_cmd_pkg::IDX_LO2:  txb = second_w[7:0];
                sensor_cmd_pkg::IDX_CRC1,
                sensor_cmd_pkg::IDX_CRC2: begin
                    txb = q_r.crc;
                    tx_crc = 1'b1;
                end
                default:                  txb = sensor_cmd_pkg::IDLE_BYTE;
            endcase
        // RQ17: identifier readout
        end else if (q_r.rd_kind == sensor_cmd_pkg::RD_ID) begin
            case (q_r.byte_idx)
                sensor_cmd_pkg::IDX_HI1:  txb = sensor_cmd_pkg::PRODUCT_ID[15:8];
                sensor_cmd_pkg::IDX_LO1:  txb = sensor_cmd_pkg::PRODUCT_ID[7:0];
                sensor_cmd_pkg::IDX_CRC1: begin
                    txb = q_r.crc;
                    tx_crc = 1'b1;
                end
                default:                  txb = sensor_cmd_pkg::IDLE_BYTE;
            endcase
        end

        // Bus conditions override any phase
        if (start) begin
            q_nxt.st = sensor_cmd_pkg::S_ADDR;
            q_nxt.bit_cnt = 4'h0;
            q_nxt.sda_oe_n = 1'b1;
        end else if (stop) begin
            q_nxt.st = sensor_cmd_pkg::S_IDLE;
            q_nxt.sda_oe_n = 1'b1;
            q_nxt.scl_oe_n = 1'b1;
        end else begin
            unique case (q_r.st)
                // Waiting for a start
                sensor_cmd_pkg::S_IDLE, sensor_cmd_pkg::S_WAIT: begin
                    q_nxt.sda_oe_n = 1'b1;
                end
                // Header and command bytes sampled on rising edge
                sensor_cmd_pkg::S_ADDR, sensor_cmd_pkg::S_WR: begin
                    if (rise) begin
                        q_nxt.shreg = {q_r.shreg[6:0], sda_fv};
                        q_nxt.bit_cnt = q_r.bit_cnt + 4'h1;
                    end else if (fall && q_r.bit_cnt == sensor_cmd_pkg::BYTE_BITS) begin
                        q_nxt.byte_idx = (q_r.st == sensor_cmd_pkg::S_ADDR) ? 3'h0 : q_r.byte_idx;
                        if (q_r.st == sensor_cmd_pkg::S_WR) begin
                            q_nxt.sda_oe_n = 1'b0;
                            q_nxt.st = sensor_cmd_pkg::S_WACK;
                        // RQ9: busy without stretch refuses all
                        end else if (addr_hit && !(q_r.busy && !(q_r.stretch_sel && q_r.shreg[0]))) begin
                            q_nxt.sda_oe_n = 1'b0;
                            q_nxt.rw = q_r.shreg[0];
                            q_nxt.is_gc = (q_r.shreg == sensor_cmd_pkg::GC_WRITE);
                            q_nxt.st = sensor_cmd_pkg::S_ACK;
                        end else begin
                            q_nxt.st = sensor_cmd_pkg::S_WAIT;
                        end
                    end
                end
                // Header acknowledged; ends on falling edge
                sensor_cmd_pkg::S_ACK: begin
                    if (fall) begin
                        q_nxt.sda_oe_n = 1'b1;
                        q_nxt.bit_cnt = 4'h0;
                        if (!q_r.rw) begin
                            q_nxt.st = sensor_cmd_pkg::S_WR;
                        // RQ10: hold clock low while converting
                        end else if (q_r.busy) begin
                            q_nxt.scl_oe_n = 1'b0;
                            q_nxt.st = sensor_cmd_pkg::S_STRETCH;
                        end else begin
                            load = 1'b1;
                        end
                    end
                end
                // RQ10: release clock with first bit ready
                sensor_cmd_pkg::S_STRETCH: begin
                    if (!q_r.busy) begin
                        q_nxt.scl_oe_n = 1'b1;
                        load = 1'b1;
                    end
                end
                // Command byte acknowledged
                sensor_cmd_pkg::S_WACK: begin
                    if (fall) begin
                        q_nxt.sda_oe_n = 1'b1;
                        q_nxt.bit_cnt = 4'h0;
                        q_nxt.st = sensor_cmd_pkg::S_WR;
                        // RQ16: general call reset byte
                        if (q_r.is_gc) begin
                            do_reset = (q_r.shreg == sensor_cmd_pkg::GC_RESET_BYTE);
                        // RQ2: high byte kept first
                        end else if (q_r.byte_idx == 3'h0) begin
                            q_nxt.cmd_hi = q_r.shreg;
                            q_nxt.byte_idx = 3'h1;
                        end else begin
                            q_nxt.byte_idx = 3'h0;
                            // RQ5: asleep only wake-up counts
                            if (q_r.asleep) begin
                                q_nxt.asleep = (cmd != sensor_cmd_pkg::CMD_WAKE);
                            end else begin
                                case (cmd)
                                    sensor_cmd_pkg::CMD_SLEEP:    q_nxt.asleep = 1'b1;
                                    // RQ15: soft reset command
                                    sensor_cmd_pkg::CMD_SOFT_RST: do_reset = 1'b1;
                                    sensor_cmd_pkg::CMD_IDENTIFIER_READOUT_COMMAND:  q_nxt.rd_kind = sensor_cmd_pkg::RD_ID;
                                    // RQ6: normal-power codes
                                    sensor_cmd_pkg::CMD_N_ST_T:   {mv, ms, ml, mt} = {1'b1, 1'b1, 1'b0, 1'b1};
                                    sensor_cmd_pkg::CMD_N_ST_H:   {mv, ms, ml, mt} = {1'b1, 1'b1, 1'b0, 1'b0};
                                    sensor_cmd_pkg::CMD_N_NS_T:   {mv, ms, ml, mt} = {1'b1, 1'b0, 1'b0, 1'b1};
                                    sensor_cmd_pkg::CMD_N_NS_H:   {mv, ms, ml, mt} = {1'b1, 1'b0, 1'b0, 1'b0};
                                    // RQ7: low-power codes
                                    sensor_cmd_pkg::CMD_L_ST_T:   {mv, ms, ml, mt} = {1'b1, 1'b1, 1'b1, 1'b1};
                                    sensor_cmd_pkg::CMD_L_ST_H:   {mv, ms, ml, mt} = {1'b1, 1'b1, 1'b1, 1'b0};
                                    sensor_cmd_pkg::CMD_L_NS_T:   {mv, ms, ml, mt} = {1'b1, 1'b0, 1'b1, 1'b1};
                                    sensor_cmd_pkg::CMD_L_NS_H:   {mv, ms, ml, mt} = {1'b1, 1'b0, 1'b1, 1'b0};
                                    // Unknown or wake while awake: ignored
                                    default:                      mv = 1'b0;
                                endcase
                            end
                        end
                    end
                end
                // Shift out on falling edges
                sensor_cmd_pkg::S_RD: begin
                    if (fall) begin
                        if (q_r.bit_cnt == sensor_cmd_pkg::BIT_LAST) begin
                            q_nxt.sda_oe_n = 1'b1;
                            q_nxt.st = sensor_cmd_pkg::S_RACK;
                        end else begin
                            q_nxt.shreg = {q_r.shreg[6:0], 1'b0};
                            q_nxt.sda_oe_n = q_r.shreg[6];
                            q_nxt.bit_cnt = q_r.bit_cnt + 4'h1;
                        end
                    end
                end
                // RQ13: host acknowledge decides continuation
                sensor_cmd_pkg::S_RACK: begin
                    if (rise && sda_fv) begin
                        q_nxt.st = sensor_cmd_pkg::S_WAIT;
                    end else if (fall) begin
                        load = 1'b1;
                    end
                end
                default: q_nxt.st = sensor_cmd_pkg::S_IDLE;
            endcase
        end

        // Measurement start latches its options
        if (mv) begin
            q_nxt.busy = 1'b1;
            q_nxt.meas_start = 1'b1;
            q_nxt.stretch_sel = ms;
            q_nxt.low_power = ml;
            q_nxt.temp_first = mt;
            q_nxt.rd_kind = sensor_cmd_pkg::RD_MEAS;
        end
        // Next byte goes out; pin driven low for a zero
        if (load) begin
            q_nxt.shreg = txb;
            q_nxt.sda_oe_n = txb[7];
            q_nxt.bit_cnt = 4'h0;
            q_nxt.byte_idx = q_r.byte_idx + 3'h1;
            q_nxt.st = sensor_cmd_pkg::S_RD;
            // RQ18: checksum over two preceding bytes
            if (!tx_crc) begin
                q_nxt.crc = crc8(tx_new ? sensor_cmd_pkg::CRC_INIT : q_r.crc, txb);
            end
        end
        // RQ15: same effect as power-on, pins kept sampled
        if (do_reset) begin
            q_nxt = sensor_cmd_pkg::ST_RST;
            q_nxt.scl_s = {q_r.scl_s[1:0], scl_in};
            q_nxt.sda_s = {q_r.sda_s[1:0], sda_in};
            q_nxt.scl_f = scl_fv;
            q_nxt.sda_f = sda_fv;
            q_nxt.soft_rst = 1'b1;
        end
    end

    // RQ3: state register, power-on reset to idle
    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            q_r <= sensor_cmd_pkg::ST_RST;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Open-drain pins only ever pull low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe_n_out = q_r.scl_oe_n;
    assign sda_oe_n_out = q_r.sda_oe_n;
    assign meas_start_out = q_r.meas_start;
    assign meas_low_power_out = q_r.low_power;
    assign meas_temp_first_out = q_r.temp_first;
    assign sleep_out = q_r.asleep;
    assign soft_reset_out = q_r.soft_rst;

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);

    ack_only_match_a: assert property (q_r.st == sensor_cmd_pkg::S_ACK |-> addr_hit && !q_r.sda_oe_n) // RQ1
        else $error("Header acknowledged without address match");
    nack_busy_a: assert property (q_r.st == sensor_cmd_pkg::S_ADDR && fall && !start && !stop
        && q_r.bit_cnt == sensor_cmd_pkg::BYTE_BITS && q_r.busy && !q_r.stretch_sel // RQ9
        |=> q_r.st == sensor_cmd_pkg::S_WAIT && q_r.sda_oe_n)
        else $error("Header acknowledged during conversion");
    stretch_hold_a: assert property (q_r.st == sensor_cmd_pkg::S_STRETCH && q_r.busy && !start && !stop // RQ10
        |=> !q_r.scl_oe_n)
        else $error("Clock not held during conversion");
    stretch_end_a: assert property (q_r.st == sensor_cmd_pkg::S_STRETCH && !q_r.busy && !start && !stop // RQ10
        |=> q_r.scl_oe_n && q_r.st == sensor_cmd_pkg::S_RD && q_r.byte_idx == sensor_cmd_pkg::IDX_LO1)
        else $error("Clock not released after conversion");
    meas_busy_a: assert property ($rose(q_r.busy) |-> q_r.meas_start && q_r.rd_kind == sensor_cmd_pkg::RD_MEAS) // RQ6
        else $error("Conversion begun without a start pulse");
    sleep_block_a: assert property (q_r.asleep |=> !q_r.meas_start) // RQ5
        else $error("Measurement started while asleep");
    nack_release_a: assert property (q_r.st == sensor_cmd_pkg::S_RACK && rise && sda_fv && !start && !stop // RQ13
        |=> q_r.st == sensor_cmd_pkg::S_WAIT ##1 q_r.sda_oe_n)
        else $error("Transmission continued after host NACK");
    reset_state_a: assert property (q_r.soft_rst |-> q_r.st == sensor_cmd_pkg::S_IDLE && !q_r.busy // RQ15
        && !q_r.asleep && q_r.sda_oe_n && q_r.scl_oe_n)
        else $error("Soft reset left state behind");
    crc_vector_a: assert property (crc8(crc8(sensor_cmd_pkg::CRC_INIT, sensor_cmd_pkg::CRC_CHK_HI), // RQ18
        sensor_cmd_pkg::CRC_CHK_LO) == sensor_cmd_pkg::CRC_CHK_VAL)
        else $error("Checksum function wrong");

    stretch_seen_c: cover property (q_r.st == sensor_cmd_pkg::S_STRETCH ##1 q_r.st == sensor_cmd_pkg::S_RD);
    meas_seen_c: cover property (q_r.meas_start);
    reset_seen_c: cover property (q_r.soft_rst);
    nack_seen_c: cover property (q_r.st == sensor_cmd_pkg::S_RACK ##1 q_r.st == sensor_cmd_pkg::S_WAIT);
endmodule : sensor_i2c_command_interface

// File: i2c_host_model.sv
`timescale 1ns/1ps
// Host controller on the far side; 160 ns bit period
module i2c_host_model (
    input  wire logic scl_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_out
);
    // Released lines read high through the pull-ups
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    // One bit; waits while the device holds the clock low
    task automatic xbit(input logic b, output logic r);
        sda_out = b;
        #40 scl_out = 1'b1;
        wait (scl_in);
        #80 r = sda_in;
        scl_out = 1'b0;
        #40;
    endtask : xbit
    // Start condition: data falls while clock high
    task automatic start();
        sda_out = 1'b1;
        scl_out = 1'b1;
        #80 sda_out = 1'b0;
        #80 scl_out = 1'b0;
        #40;
    endtask : start
    // Stop condition: data rises while clock high
    task automatic stop();
        sda_out = 1'b0;
        #40 scl_out = 1'b1;
        #80 sda_out = 1'b1;
        #80;
    endtask : stop
    // Byte out, msb first; returns the acknowledge
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xbit(d[i], r);
        xbit(1'b1, r);
        ack = ~r;
    endtask : wbyte
    task automatic rbyte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, r);
            d[i] = r;
        end
        xbit(~ack, r);
    endtask : rbyte
endmodule : i2c_host_model

// File: sensor_i2c_command_interface_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin mismatches++; $display("Error %s expected %h seen %h", n, e, g); end end
module sensor_i2c_command_interface_test;
    // Code, then low power, temp first, stretch
    typedef struct packed {logic [15:0] code; logic lp; logic tf; logic st;} row_t;
    row_t rows [8] = '{{16'h7CA2, 3'b011}, {16'h5C24, 3'b001}, {16'h7866, 3'b010}, {16'h58E0, 3'b000},
                       {16'h6458, 3'b111}, {16'h44DE, 3'b101}, {16'h609C, 3'b110}, {16'h401A, 3'b100}};
    logic clk_sys_in = 1'b0, rst_in = 1'b1, conv_done_in = 1'b0, a;
    logic [15:0] temp_in = 16'h0000, hum_in = 16'h0000, f, s;
    logic [7:0] b;
    logic scl_out, scl_oe_n_out, sda_out, sda_oe_n_out, meas_start_out, host_scl, host_sda;
    logic meas_low_power_out, meas_temp_first_out, sleep_out, soft_reset_out;
    int mismatches = 0, n_compared = 0, cycles = 0, starts = 0, resets = 0, conv_cnt = 0, stretch_cyc = 0;
    int base, n0;
    // Wired-AND of both parties on each line
    wire logic scl_w = host_scl & (scl_oe_n_out ? 1'b1 : scl_out);
    wire logic sda_w = host_sda & (sda_oe_n_out ? 1'b1 : sda_out);
    always #2.5 clk_sys_in = ~clk_sys_in;
    sensor_i2c_command_interface u_sensor_i2c_command_interface (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
        .scl_in(scl_w), .sda_in(sda_w), .conv_done_in(conv_done_in), .temp_in(temp_in), .hum_in(hum_in),
        .scl_out(scl_out), .scl_oe_n_out(scl_oe_n_out), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
        .meas_start_out(meas_start_out), .meas_low_power_out(meas_low_power_out),
        .meas_temp_first_out(meas_temp_first_out), .sleep_out(sleep_out), .soft_reset_out(soft_reset_out));
    i2c_host_model u_i2c_host_model (.scl_in(scl_w), .sda_in(sda_w), .scl_out(host_scl), .sda_out(host_sda));
    // Sensor core stand-in: 2000-cycle conversion; pulse counters; hang guard
    always @(posedge clk_sys_in) begin
        cycles <= cycles + 1;
        conv_done_in <= 1'b0;
        if (conv_cnt != 0) conv_cnt <= conv_cnt - 1;
        if (conv_cnt == 1) conv_done_in <= 1'b1;
        if (meas_start_out) conv_cnt <= 2000;
        starts <= starts + int'(meas_start_out);
        resets <= resets + int'(soft_reset_out);
        stretch_cyc <= stretch_cyc + int'(!scl_oe_n_out);
        if (cycles == 90000) begin
            mismatches++;
            end_of_test();
        end
    end
    // Reference checksum: poly 0x31, start 0xFF, no reflection
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
        return c;
    endfunction : crc8
    // header 0x70 write, high byte first
    task automatic cmd(input logic [15:0] c);
        u_i2c_host_model.start();
        u_i2c_host_model.wbyte(8'hE0, a);
        `CHK("write header", 1'b1, a)
        u_i2c_host_model.wbyte(c[15:8], a);
        u_i2c_host_model.wbyte(c[7:0], a);
        u_i2c_host_model.stop();
    endtask : cmd
    // Read header; refused header is closed at once
    task automatic hdr(output logic ack);
        u_i2c_host_model.start();
        u_i2c_host_model.wbyte(8'hE1, ack);
        if (ack !== 1'b1) u_i2c_host_model.stop();
    endtask : hdr
    // Data word then checksum; last one NACKed
    task automatic rd_pair(input logic [15:0] v, input logic last);
        u_i2c_host_model.rbyte(1'b1, b);
        `CHK("data high", v[15:8], b)
        u_i2c_host_model.rbyte(1'b1, b);
        `CHK("data low", v[7:0], b)
        u_i2c_host_model.rbyte(!last, b);
        `CHK("checksum", crc8(v), b)
    endtask : rd_pair
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (20) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        `CHK("sleep after reset", 1'b0, sleep_out)
        `CHK("sda after reset", 1'b1, sda_oe_n_out)
        $display("test reset done");
        foreach (rows[i]) begin
            @(posedge clk_sys_in);
            temp_in <= 16'hBEEF + 16'(i);
            hum_in <= ~rows[i].code;
            base = stretch_cyc;
            n0 = starts;
            // only the read header during conversion
            cmd(rows[i].code);
            `CHK("start pulses", n0 + 1, starts)
            `CHK("low power", rows[i].lp, meas_low_power_out)
            `CHK("temp first", rows[i].tf, meas_temp_first_out)
            hdr(a);
            `CHK("header in conversion", rows[i].st, a)
            for (int k = 0; k < 40 && a !== 1'b1; k++) hdr(a);
            f = rows[i].tf ? temp_in : hum_in;
            s = rows[i].tf ? hum_in : temp_in;
            rd_pair(f, 1'b0);
            rd_pair(s, 1'b1);
            u_i2c_host_model.stop();
            `CHK("clock held", rows[i].st, stretch_cyc != base)
            $display("test measure %h done", rows[i].code);
        end
        cmd(16'hB098);
        `CHK("asleep", 1'b1, sleep_out)
        n0 = starts;
        cmd(16'h7866);
        `CHK("measure asleep", n0, starts)
        cmd(16'h3517);
        `CHK("awake", 1'b0, sleep_out)
        $display("test sleep done");
        cmd(16'hEFC8);
        hdr(a);
        rd_pair(sensor_cmd_pkg::PRODUCT_ID, 1'b1);
        u_i2c_host_model.stop();
        cmd(16'hEFC8);
        hdr(a);
        u_i2c_host_model.rbyte(1'b0, b);
        repeat (40) @(posedge clk_sys_in);
        `CHK("released after nack", 1'b1, sda_oe_n_out)
        u_i2c_host_model.stop();
        $display("test identifier done");
        u_i2c_host_model.start();
        u_i2c_host_model.wbyte(8'hE2, a);
        `CHK("foreign address", 1'b0, a)
        u_i2c_host_model.stop();
        n0 = resets;
        u_i2c_host_model.start();
        u_i2c_host_model.wbyte(8'h00, a);
        `CHK("general call", 1'b1, a)
        u_i2c_host_model.wbyte(8'h06, a);
        `CHK("reset byte", 1'b1, a)
        u_i2c_host_model.stop();
        `CHK("general reset", n0 + 1, resets)
        cmd(16'h805D);
        `CHK("soft reset", n0 + 2, resets)
        $display("test resets done");
        end_of_test();
    end
endmodule : sensor_i2c_command_interface_test
